// >>> dpoi_beep.sv
// Beep pacing, tone generation and volume shaping from unfiltered pulses.
`timescale 1ns/10ps
module dpoi_beep #(
  parameter int unsigned BEEP_LEN = dpoi_pkg::BEEP_CYCLES
) (
  // Clock, reset and enable.
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          ce,
  // Settings and pulse events.
  input  wire logic                          pulse_evt,
  input  wire logic                          cnt_clr,
  input  wire logic [31:0]                   pulses_per_beep,
  input  wire logic [31:0]                   tone_hz,
  input  wire logic [dpoi_pkg::VOL_W-1:0]    volume,
  // Speaker drive.
  output logic                               speaker_out
);

  logic [31:0]                acc_q, acc_d;
  logic [31:0]                dur_q, dur_d;
  logic [31:0]                ph_q, ph_d;
  logic                       tone_q, tone_d;
  logic [dpoi_pkg::VOL_W-1:0] pwm_q, pwm_d;
  logic                       spk_q, spk_d;
  logic [dpoi_pkg::VOL_W-1:0] vol_eff;
  logic [32:0]                ph_sum;

  // ==========================================================================
  // Volume never falls below the least audible level.
  assign vol_eff = (volume < dpoi_pkg::VOL_MIN) ? dpoi_pkg::VOL_MIN : volume;
  assign ph_sum  = {1'b0, ph_q} + {tone_hz[31:0], 1'b0};

  // Pulse accumulator, beep timer, tone phase and volume PWM.
  always_comb
  begin
    acc_d  = acc_q;
    dur_d  = dur_q;
    ph_d   = ph_q;
    tone_d = tone_q;
    pwm_d  = pwm_q;
    spk_d  = spk_q;
    if (ce)
    begin
      if (cnt_clr)
        acc_d = '0;
      else if (pulse_evt)
      begin
        // One tick per programmed count of unfiltered pulses.
        if (acc_q + 32'h00000001 >= pulses_per_beep)
        begin
          acc_d = '0;
          dur_d = 32'(BEEP_LEN);
        end
        else
          acc_d = acc_q + 32'h00000001;
      end
      if (dur_q != '0 && !(pulse_evt && dur_d != dur_q))
        dur_d = dur_q - 32'h00000001;
      // Phase wraps at the clock rate, toggling twice per tone period.
      if (ph_sum >= 33'(dpoi_pkg::CLK_HZ))
      begin
        ph_d   = 32'(ph_sum - 33'(dpoi_pkg::CLK_HZ));
        tone_d = !tone_q;
      end
      else
        ph_d = ph_sum[31:0];
      pwm_d = pwm_q + 3'h1;
      spk_d = (dur_q != '0) && tone_q && (pwm_q < vol_eff);
    end
  end

  // Register the beep state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_q  <= '0;
      dur_q  <= '0;
      ph_q   <= '0;
      tone_q <= 1'b0;
      pwm_q  <= '0;
      spk_q  <= 1'b0;
    end
    else
    begin
      acc_q  <= acc_d;
      dur_q  <= dur_d;
      ph_q   <= ph_d;
      tone_q <= tone_d;
      pwm_q  <= pwm_d;
      spk_q  <= spk_d;
    end
  end

  assign speaker_out = spk_q;

endmodule

// >>> dpoi_checker.sv
// Concurrent checks on the ports of the dose pulse overflow interlock.
`timescale 1ns/10ps
module dpoi_checker #(
  parameter int unsigned BEEP_LEN = 50
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Bus and pins.
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire logic watchdog_in,
  input wire logic emergency_off_switch_in,
  input wire logic emergency_off_switch_out,
  // Relays, contacts and rings.
  input wire logic overflow_relay_closed,
  input wire logic pause_relay_closed,
  input wire logic key_off_contact,
  input wire logic key_prepare_position_contact,
  input wire logic key_treat_contact,
  input wire logic start_ring_green,
  input wire logic start_ring_red,
  input wire logic pause_ring_green,
  input wire logic pause_ring_red
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================================
  // Watchdog held long enough to cross the synchroniser.
  sequence s_wdog_held;
    watchdog_in [*3];
  endsequence

  a_estop_direct: assert property (emergency_off_switch_out == emergency_off_switch_in)
    else $error("stop output differs from switch");
  a_key_onehot: assert property ($onehot({key_off_contact, key_prepare_position_contact,
    key_treat_contact})) else $error("key contacts not one-hot");
  a_start_ring: assert property (start_ring_green != start_ring_red)
    else $error("start ring colour invalid");
  a_pause_ring: assert property (pause_ring_green |-> key_treat_contact && !pause_ring_red)
    else $error("pause ring green outside treat");
  a_start_gate: assert property (start_ring_green |-> overflow_relay_closed && key_treat_contact)
    else $error("start ring green while blocked");
  a_pause_relay: assert property (pause_relay_closed |-> key_treat_contact)
    else $error("pause relay closed outside treat");
  a_wdog_opens: assert property (s_wdog_held |-> !overflow_relay_closed)
    else $error("relay closed under watchdog");
  a_slverr_phase: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
endmodule

// >>> dpoi_pkg.sv
// Package of constants and types for the dose pulse overflow interlock.
// Notes on behaviour
// - With the coaxial input fitted, a disconnected pulse cable is flagged.
// - Pulses are counted as plain events, with no meaning attached.
// - Beam is valid, letting pulses through, whenever either qualifier is high.
// - Unfiltered counter counts every pulse since the last counter reset.
// - Filtered counter counts only pulses that the qualifiers let through.
// - Relay opens when the filtered count exceeds the target, never unfiltered.
// - Overflow relay rests closed; opens only on overflow or watchdog.
// - Both counts are readable by the client.
// - Beep ticks follow the unfiltered count, not the filtered count.
// - Beep volume is adjustable, but no setting silences it.
// - Three-position keyswitch decodes to off, prepare and treat, and is reported.
// - Keyswitch position feeds the relay control logic.
// - Start and pause rings show green when available, red when suppressed.
// - Emergency off contacts pass straight to the rear stop outputs.
// - A pulses-per-beep setting sets unfiltered pulses per beep tick.
// - A tone setting in hertz sets the frequency of each beep.
// - Pause relay rests open; closes only in treatment with a pause press seen.
// - Each keyswitch position has its own contact, closed only in that position.
package dpoi_pkg;

  // ==========================================================================
  // Timing.
  localparam int unsigned CLK_HZ      = 25000000;
  localparam int unsigned BEEP_MS     = 20;
  localparam int unsigned BEEP_CYCLES = CLK_HZ / 1000 * BEEP_MS;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_TARGET = 8'h04;
  localparam logic [7:0] OFS_UNFILT = 8'h08;
  localparam logic [7:0] OFS_FILT   = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_PPB    = 8'h14;
  localparam logic [7:0] OFS_TONE   = 8'h18;
  localparam logic [7:0] OFS_VOLUME = 8'h1C;

  // ==========================================================================
  // Control register bits.
  localparam int unsigned CTRL_CLR        = 0;
  localparam int unsigned CTRL_START_AV   = 1;
  localparam int unsigned CTRL_PAUSE_AV   = 2;
  localparam int unsigned CTRL_COAX_OPT   = 3;
  localparam int unsigned CTRL_PAUSE_CLR  = 4;
  localparam int unsigned CTRL_W          = 5;

  // ==========================================================================
  // Status register bits.
  localparam int unsigned ST_OVF       = 0;
  localparam int unsigned ST_CABLE     = 1;
  localparam int unsigned ST_KEY_LO    = 2;
  localparam int unsigned ST_PAUSE_SEEN = 4;
  localparam int unsigned ST_OVF_RELAY = 5;
  localparam int unsigned ST_PAUSE_RLY = 6;
  localparam int unsigned ST_WDOG      = 7;

  // ==========================================================================
  // Widths and reset values.
  localparam int unsigned VOL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST   = 5'h00;
  localparam logic [31:0]       TARGET_RST = 32'hFFFFFFFF;
  localparam logic [31:0]       PPB_RST    = 32'h00000064;
  localparam logic [31:0]       TONE_RST   = 32'h000003E8;
  localparam logic [VOL_W-1:0]  VOL_RST    = 3'h4;
  localparam logic [VOL_W-1:0]  VOL_MIN    = 3'h1;

  // ==========================================================================
  // Decoded keyswitch position.
  typedef enum logic [1:0] {
    KEY_OFF,
    KEY_PREPARE_POSITION,
    KEY_TREAT_POSITION
  } dpoi_key_t;

endpackage

// >>> dpoi_pulse_src.sv
// Model of the pulse source and the beam qualifier outputs.
`timescale 1ns/10ps
module dpoi_pulse_src (
  // Clock.
  input wire logic pclk,
  // Pulse and qualifier pins.
  output logic     dose_pulse_in,
  output logic     qual_a_in,
  output logic     qual_b_in
);
  // ==========================================================================
  // Sends n pulses, 1 us high and 240 ns low, under the given qualifiers.
  task automatic burst(input int n, input logic qa, input logic qb);
    begin
      qual_a_in <= qa;
      qual_b_in <= qb;
      repeat (n)
      begin
        @(posedge pclk);
        dose_pulse_in <= 1'b1;
        repeat (25) @(posedge pclk);
        dose_pulse_in <= 1'b0;
        repeat (5) @(posedge pclk);
      end
      repeat (4) @(posedge pclk);
      qual_a_in <= 1'b0;
      qual_b_in <= 1'b0;
    end
  endtask

  // Idle levels at time zero.
  initial
  begin
    dose_pulse_in = 1'b0;
    qual_a_in     = 1'b0;
    qual_b_in     = 1'b0;
  end
endmodule

// >>> dpoi_sync.sv
// Two-flop synchroniser for a bundle of asynchronous level inputs.
`timescale 1ns/10ps
module dpoi_sync #(
  parameter int unsigned W = 1
) (
  // Clock, reset and enable.
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  // Asynchronous in, synchronous out.
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // ==========================================================================
  // Next values: the first stage is read only by the second.
  always_comb
  begin
    meta_d = ce ? async_in : meta_q;
    sync_d = ce ? meta_q : sync_q;
  end

  // Register both stages.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// >>> dpoi_top.sv
// Dose pulse counter with qualification gating, overflow interlock and APB registers.
`timescale 1ns/10ps
module dpoi_top #(
  parameter int unsigned BEEP_LEN = dpoi_pkg::BEEP_CYCLES
) (
  // Clock, reset and enable.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pulse source and qualification pins.
  input  wire logic        dose_pulse_in,
  input  wire logic        qual_a_in,
  input  wire logic        qual_b_in,
  input  wire logic        cable_present_in,
  input  wire logic        watchdog_in,
  // Keyswitch and buttons.
  input  wire logic        key_off_in,
  input  wire logic        key_prepare_position_in,
  input  wire logic        key_treat_in,
  input  wire logic        pause_button_in,
  input  wire logic        emergency_off_switch_in,
  // Relays and contacts, high means closed.
  output logic             overflow_relay_closed,
  output logic             pause_relay_closed,
  output logic             key_off_contact,
  output logic             key_prepare_position_contact,
  output logic             key_treat_contact,
  output logic             emergency_off_switch_out,
  // Indicator rings and speaker.
  output logic             start_ring_green,
  output logic             start_ring_red,
  output logic             pause_ring_green,
  output logic             pause_ring_red,
  output logic             speaker_out
);

  // ==========================================================================
  // Declarations.
  logic [7:0]                 pin_s;
  logic                       pulse_s, qual_a_s, qual_b_s, cable_s, wdog_s;
  logic                       koff_s, kprep_s, ktreat_s, pbtn_s;
  dpoi_pkg::dpoi_key_t        key;
  logic                       beam_valid, pulse_evt, cnt_clr, pause_clr;
  logic                       wr_en, rd_setup, addr_ok;

  logic                       pulse_q, pulse_d;
  logic                       pbtn_q, pbtn_d;
  logic [31:0]                unfilt_q, unfilt_d;
  logic [31:0]                filt_q, filt_d;
  logic                       ovf_q, ovf_d;
  logic                       pause_seen_q, pause_seen_d;
  logic [dpoi_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [31:0]                target_q, target_d;
  logic [31:0]                ppb_q, ppb_d;
  logic [31:0]                tone_q, tone_d;
  logic [dpoi_pkg::VOL_W-1:0] vol_q, vol_d;
  logic [31:0]                rdata_q, rdata_d;
  logic                       err_q, err_d;
  logic [31:0]                status;

  // ==========================================================================
  // Pin synchronisers for every asynchronous input but the emergency off switch.
  dpoi_sync #(
    .W (8)
  ) u_sync_pins (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .async_in ({dose_pulse_in, qual_a_in, qual_b_in, cable_present_in,
                watchdog_in, key_off_in, key_treat_in, pause_button_in}),
    .sync_out (pin_s)
  );

  // The prepare contact is synchronised separately to keep the bundle tidy.
  dpoi_sync #(
    .W (1)
  ) u_sync_prepare_position (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .async_in (key_prepare_position_in),
    .sync_out (kprep_s)
  );

  assign {pulse_s, qual_a_s, qual_b_s, cable_s, wdog_s, koff_s, ktreat_s, pbtn_s} = pin_s;

  // ==========================================================================
  // Keyswitch decode; an illegal or missing contact pattern reads as off.
  always_comb
  begin
    if (ktreat_s && !kprep_s && !koff_s)
      key = dpoi_pkg::KEY_TREAT_POSITION;
    else if (kprep_s && !ktreat_s && !koff_s)
      key = dpoi_pkg::KEY_PREPARE_POSITION;
    else
      key = dpoi_pkg::KEY_OFF;
  end

  // Each position drives its own contact.
  assign key_off_contact              = (key == dpoi_pkg::KEY_OFF);
  assign key_prepare_position_contact = (key == dpoi_pkg::KEY_PREPARE_POSITION);
  assign key_treat_contact            = (key == dpoi_pkg::KEY_TREAT_POSITION);

  // The stop contacts bypass all logic.
  assign emergency_off_switch_out = emergency_off_switch_in;

  // ==========================================================================
  // Event decode: a pulse counts once on its rising edge, whatever it stands for.
  assign pulse_evt  = pulse_s && !pulse_q;
  assign beam_valid = qual_a_s || qual_b_s;
  assign wr_en      = psel && penable && pwrite;
  assign rd_setup   = psel && !penable;
  assign cnt_clr    = wr_en && (paddr == dpoi_pkg::OFS_CTRL) && pwdata[dpoi_pkg::CTRL_CLR];
  assign pause_clr  = wr_en && (paddr == dpoi_pkg::OFS_CTRL) && pwdata[dpoi_pkg::CTRL_PAUSE_CLR];

  // Counters, overflow latch and pause press latch.
  always_comb
  begin
    pulse_d      = pulse_q;
    pbtn_d       = pbtn_q;
    unfilt_d     = unfilt_q;
    filt_d       = filt_q;
    ovf_d        = ovf_q;
    pause_seen_d = pause_seen_q;
    if (ce)
    begin
      pulse_d  = pulse_s;
      pbtn_d   = pbtn_s;
      // A pulse in the clearing cycle is kept as the first count.
      unfilt_d = (cnt_clr ? 32'h00000000 : unfilt_q)
                 + {31'h00000000, pulse_evt};
      filt_d   = (cnt_clr ? 32'h00000000 : filt_q)
                 + {31'h00000000, pulse_evt && beam_valid};
      // Only the filtered count is compared; a detection beats a clear.
      ovf_d    = (ovf_q && !cnt_clr) || (filt_q > target_q);
      // Press is latched only in treatment; leaving treatment drops it.
      if (key != dpoi_pkg::KEY_TREAT_POSITION)
        pause_seen_d = 1'b0;
      else
        pause_seen_d = (pause_seen_q && !pause_clr) || (pbtn_s && !pbtn_q);
    end
  end

  // Register the counting state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pulse_q      <= 1'b0;
      pbtn_q       <= 1'b0;
      unfilt_q     <= '0;
      filt_q       <= '0;
      ovf_q        <= 1'b0;
      pause_seen_q <= 1'b0;
    end
    else
    begin
      pulse_q      <= pulse_d;
      pbtn_q       <= pbtn_d;
      unfilt_q     <= unfilt_d;
      filt_q       <= filt_d;
      ovf_q        <= ovf_d;
      pause_seen_q <= pause_seen_d;
    end
  end

  // ==========================================================================
  // Relays: overflow relay rests closed, pause relay rests open.
  assign overflow_relay_closed = !ovf_q && !wdog_s;
  assign pause_relay_closed    = pause_seen_q && (key == dpoi_pkg::KEY_TREAT_POSITION)
                                 && !wdog_s;

  // Indicator rings follow availability, gated by key; the start ring also by the overflow relay.
  assign start_ring_green = ctrl_q[dpoi_pkg::CTRL_START_AV]
                            && (key == dpoi_pkg::KEY_TREAT_POSITION) && overflow_relay_closed;
  assign start_ring_red   = !start_ring_green;
  assign pause_ring_green = ctrl_q[dpoi_pkg::CTRL_PAUSE_AV]
                            && (key == dpoi_pkg::KEY_TREAT_POSITION);
  assign pause_ring_red   = !pause_ring_green;

  // ==========================================================================
  // Status word gathered from live state.
  always_comb
  begin
    status = '0;
    status[dpoi_pkg::ST_OVF]                          = ovf_q;
    status[dpoi_pkg::ST_CABLE]                        = ctrl_q[dpoi_pkg::CTRL_COAX_OPT]
                                                        && !cable_s;
    status[dpoi_pkg::ST_KEY_LO+1:dpoi_pkg::ST_KEY_LO] = key;
    status[dpoi_pkg::ST_PAUSE_SEEN]                   = pause_seen_q;
    status[dpoi_pkg::ST_OVF_RELAY]                    = overflow_relay_closed;
    status[dpoi_pkg::ST_PAUSE_RLY]                    = pause_relay_closed;
    status[dpoi_pkg::ST_WDOG]                         = wdog_s;
  end

  // Address check for the current transfer.
  always_comb
  begin
    unique case (paddr)
      dpoi_pkg::OFS_CTRL, dpoi_pkg::OFS_TARGET, dpoi_pkg::OFS_UNFILT, dpoi_pkg::OFS_FILT,
      dpoi_pkg::OFS_STATUS, dpoi_pkg::OFS_PPB, dpoi_pkg::OFS_TONE, dpoi_pkg::OFS_VOLUME:
        addr_ok = 1'b1;
      default:
        addr_ok = 1'b0;
    endcase
  end

  // Register writes in the access phase and read capture in the setup phase.
  always_comb
  begin
    ctrl_d   = ctrl_q;
    target_d = target_q;
    ppb_d    = ppb_q;
    tone_d   = tone_q;
    vol_d    = vol_q;
    rdata_d  = rdata_q;
    err_d    = err_q;
    if (ce)
    begin
      // Pulse bits never store.
      ctrl_d[dpoi_pkg::CTRL_CLR]       = 1'b0;
      ctrl_d[dpoi_pkg::CTRL_PAUSE_CLR] = 1'b0;
      if (wr_en)
      begin
        unique case (paddr)
          dpoi_pkg::OFS_CTRL:
          begin
            ctrl_d                           = pwdata[dpoi_pkg::CTRL_W-1:0];
            ctrl_d[dpoi_pkg::CTRL_CLR]       = 1'b0;
            ctrl_d[dpoi_pkg::CTRL_PAUSE_CLR] = 1'b0;
          end
          dpoi_pkg::OFS_TARGET: target_d = pwdata;
          dpoi_pkg::OFS_PPB:    ppb_d    = pwdata;
          dpoi_pkg::OFS_TONE:   tone_d   = pwdata;
          dpoi_pkg::OFS_VOLUME: vol_d    = pwdata[dpoi_pkg::VOL_W-1:0];
          default:              ctrl_d   = ctrl_d;
        endcase
      end
      if (rd_setup)
      begin
        err_d = !addr_ok;
        unique case (paddr)
          dpoi_pkg::OFS_CTRL:   rdata_d = {27'h0000000, ctrl_q};
          dpoi_pkg::OFS_TARGET: rdata_d = target_q;
          dpoi_pkg::OFS_UNFILT: rdata_d = unfilt_q;
          dpoi_pkg::OFS_FILT:   rdata_d = filt_q;
          dpoi_pkg::OFS_STATUS: rdata_d = status;
          dpoi_pkg::OFS_PPB:    rdata_d = ppb_q;
          dpoi_pkg::OFS_TONE:   rdata_d = tone_q;
          dpoi_pkg::OFS_VOLUME: rdata_d = {29'h00000000, vol_q};
          default:              rdata_d = 32'h00000000;
        endcase
      end
    end
  end

  // Register the bus-visible state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q   <= dpoi_pkg::CTRL_RST;
      target_q <= dpoi_pkg::TARGET_RST;
      ppb_q    <= dpoi_pkg::PPB_RST;
      tone_q   <= dpoi_pkg::TONE_RST;
      vol_q    <= dpoi_pkg::VOL_RST;
      rdata_q  <= '0;
      err_q    <= 1'b0;
    end
    else
    begin
      ctrl_q   <= ctrl_d;
      target_q <= target_d;
      ppb_q    <= ppb_d;
      tone_q   <= tone_d;
      vol_q    <= vol_d;
      rdata_q  <= rdata_d;
      err_q    <= err_d;
    end
  end

  // Zero-wait slave; the error flag only shows during an access phase.
  assign pready  = 1'b1;
  assign prdata  = rdata_q;
  assign pslverr = psel && penable && err_q;

  // ==========================================================================
  // Beep generator, fed by unfiltered pulses only.
  dpoi_beep #(
    .BEEP_LEN (BEEP_LEN)
  ) u_beep (
    .pclk            (pclk),
    .presetn         (presetn),
    .ce              (ce),
    .pulse_evt       (pulse_evt),
    .cnt_clr         (cnt_clr),
    .pulses_per_beep (ppb_q),
    .tone_hz         (tone_q),
    .volume          (vol_q),
    .speaker_out     (speaker_out)
  );

endmodule

// >>> tb_dose_pulse_overflow_interlock.sv
// Self-checking bench for the dose pulse overflow interlock.
`timescale 1ns/10ps
module tb_dose_pulse_overflow_interlock;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic dose_pulse_in, qual_a_in, qual_b_in, cable_present_in, watchdog_in;
  logic key_off_in, key_prepare_position_in, key_treat_in, pause_button_in;
  logic emergency_off_switch_in, emergency_off_switch_out, speaker_out;
  logic overflow_relay_closed, pause_relay_closed;
  logic key_off_contact, key_prepare_position_contact, key_treat_contact;
  logic start_ring_green, start_ring_red, pause_ring_green, pause_ring_red;
  int fails, cmp_count, spk_n;
  int rows [4][5] = '{'{3, 0, 0, 3, 0}, '{2, 1, 0, 2, 2}, '{4, 0, 1, 4, 4}, '{2, 1, 1, 2, 2}};
  logic [7:0] ra [4] = '{8'h14, 8'h18, 8'h1C, 8'h04};
  logic [31:0] rv [4] = '{32'h00000064, 32'h000003E8, 32'h00000004, 32'hFFFFFFFF};

  dpoi_top #(.BEEP_LEN(50)) u_dpoi_top (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .dose_pulse_in, .qual_a_in, .qual_b_in,
    .cable_present_in, .watchdog_in, .key_off_in, .key_prepare_position_in, .key_treat_in,
    .pause_button_in, .emergency_off_switch_in, .overflow_relay_closed, .pause_relay_closed,
    .key_off_contact, .key_prepare_position_contact, .key_treat_contact,
    .emergency_off_switch_out, .start_ring_green, .start_ring_red, .pause_ring_green,
    .pause_ring_red, .speaker_out);
  dpoi_pulse_src u_dpoi_pulse_src (.pclk, .dose_pulse_in, .qual_a_in, .qual_b_in);

  // Clock and speaker activity counter.
  always #20 pclk = ~pclk;
  always @(posedge pclk) if (speaker_out === 1'b1) spk_n++;

  // ==========================================================================
  // One APB transfer; waits for pready and takes data and error at that edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Compare tasks for words and single bits.
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    begin
      cmp_count++;
      if (g !== e)
      begin
        fails++;
        $display("unexpected at %0t: word %h, want %h", $time, g, e);
      end
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    begin
      cmp_count++;
      if (g !== e)
      begin
        fails++;
        $display("unexpected at %0t: bit %b, want %b", $time, g, e);
      end
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic test_done;
    begin
      if (fails == 0 && cmp_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  // Watchdog on the whole run.
  initial
  begin
    #400000;
    fails++;
    test_done;
  end

  // ==========================================================================
  // Main sequence.
  initial
  begin
    {pclk, psel, penable, pwrite, paddr, pwdata, watchdog_in, pause_button_in} = '0;
    {key_prepare_position_in, key_treat_in, emergency_off_switch_in, spk_n} = '0;
    {presetn, key_off_in, cable_present_in, fails, cmp_count} = {3'b011, 64'd0};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk1(overflow_relay_closed, 1'b1);
    chk1(key_off_contact, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, ra[i], 32'h0);
      chk32(rd, rv[i]);
    end
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, 8'h00, 32'h00000001);
      u_dpoi_pulse_src.burst(rows[i][0], rows[i][1][0], rows[i][2][0]);
      apb(1'b0, 8'h08, 32'h0);
      chk32(rd, 32'(rows[i][3]));
      apb(1'b0, 8'h0C, 32'h0);
      chk32(rd, 32'(rows[i][4]));
    end
    apb(1'b1, 8'h04, 32'h00000002);
    apb(1'b1, 8'h00, 32'h00000001);
    u_dpoi_pulse_src.burst(2, 1'b1, 1'b0);
    chk1(overflow_relay_closed, 1'b1);
    u_dpoi_pulse_src.burst(3, 1'b0, 1'b0);
    chk1(overflow_relay_closed, 1'b1);
    u_dpoi_pulse_src.burst(1, 1'b0, 1'b1);
    chk1(overflow_relay_closed, 1'b0);
    apb(1'b1, 8'h04, 32'hFFFFFFFF);
    repeat (10) @(posedge pclk);
    apb(1'b0, 8'h10, 32'h0);
    chk1(rd[0] & ~overflow_relay_closed, 1'b1);
    apb(1'b1, 8'h00, 32'h00000001);
    repeat (2) @(posedge pclk);
    chk1(overflow_relay_closed, 1'b1);
    watchdog_in <= 1'b1;
    repeat (4) @(posedge pclk);
    chk1(overflow_relay_closed, 1'b0);
    watchdog_in <= 1'b0;
    repeat (4) @(posedge pclk);
    chk1(overflow_relay_closed, 1'b1);
    key_off_in <= 1'b0;
    key_treat_in <= 1'b1;
    apb(1'b1, 8'h00, 32'h00000006);
    repeat (4) @(posedge pclk);
    chk1(key_treat_contact, 1'b1);
    chk1(start_ring_green & pause_ring_green, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    chk1(rd[3:2] === 2'h2, 1'b1);
    pause_button_in <= 1'b1;
    repeat (4) @(posedge pclk);
    chk1(pause_relay_closed, 1'b1);
    pause_button_in <= 1'b0;
    apb(1'b1, 8'h00, 32'h00000016);
    repeat (2) @(posedge pclk);
    chk1(pause_relay_closed, 1'b0);
    key_treat_in <= 1'b0;
    key_prepare_position_in <= 1'b1;
    repeat (4) @(posedge pclk);
    chk1(key_prepare_position_contact & ~pause_ring_green, 1'b1);
    cable_present_in <= 1'b0;
    emergency_off_switch_in <= 1'b1;
    apb(1'b1, 8'h00, 32'h00000008);
    repeat (4) @(posedge pclk);
    chk1(emergency_off_switch_out, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    chk1(rd[1], 1'b1);
    apb(1'b0, 8'h20, 32'h0);
    chk1(err, 1'b1);
    chk32(rd, 32'h00000000);
    apb(1'b1, 8'h14, 32'h00000002);
    apb(1'b1, 8'h18, 32'h000F4240);
    apb(1'b1, 8'h1C, 32'h00000000);
    spk_n = 0;
    u_dpoi_pulse_src.burst(2, 1'b0, 1'b0);
    repeat (60) @(posedge pclk);
    chk1(spk_n != 0, 1'b1);
    test_done;
  end
endmodule

bind dpoi_top dpoi_checker #(.BEEP_LEN(BEEP_LEN)) u_dpoi_checker (.pclk, .presetn, .psel,
  .penable, .pslverr, .watchdog_in, .emergency_off_switch_in, .emergency_off_switch_out,
  .overflow_relay_closed, .pause_relay_closed, .key_off_contact, .key_prepare_position_contact,
  .key_treat_contact, .start_ring_green, .start_ring_red, .pause_ring_green, .pause_ring_red);
